// ==== hw/request_arbiter.v ====
// picks the highest-priority pending peripheral request
`timescale 1ns/1ps
`default_nettype none
`include "vector_ctrl_consts.vh"

module request_arbiter (
    input  wire [`VC_NUM_IRQ-1:0]   pending,  // flag and enable both set
    input  wire [3*`VC_NUM_IRQ-1:0] levels,   // 3-bit priority per request
    output reg                      found,    // some request may be taken
    output reg  [7:0]               winner,   // request number of the winner
    output reg  [2:0]               level     // its user priority
);
    integer i;

    // scan from the top down so that a lower request wins a tie
    always @* begin
        found  = 1'b0;
        winner = 8'h00;
        level  = 3'h0;
        for (i = `VC_NUM_IRQ - 1; i >= 0; i = i - 1) begin
            // level zero means the source is off
            if (pending[i] && levels[3*i +: 3] != 3'h0 && levels[3*i +: 3] >= level) begin
                found  = 1'b1;
                winner = i[7:0];
                level  = levels[3*i +: 3];
            end
        end
    end
endmodule
`default_nettype wire

// ==== hw/trap_and_interrupt_vectoring.v ====
// trap and interrupt vectoring block with apb register access
//
// Notes on behaviour
// - reset clears registers, fetch starts at zero
// - reset produces no vector fetch
// - alternate entry = (limit-1)*0x800 + offset
// - request n sits at 0x14 + 2n
// - oscillator fail trap, 0x04, priority 15
// - address error trap, 0x06, priority 14
// - hard trap shared by ecc and software
// - stack error trap, 0x0A, priority 12
// - six math errors share 0x0C, priority 11
// - soft trap, three causes, priority 9
// - per-source flag, enable, 3-bit priority
// - request number is vector number minus 8
// - converter comparators use vectors 124 to 127
// - converter filters use vectors 128 to 131
// - position compare uses vector 56, 0x74
// - generator watchdog uses vector 89, 0xB6
// - equal priority favours lower table address
// - alternate enable redirects all vectoring
`timescale 1ns/1ps
`default_nettype none
`include "vector_ctrl_consts.vh"

module trap_and_interrupt_vectoring (
    input  wire                   CLK,          // system clock
    input  wire                   RESET,        // synchronous reset, high
    input  wire                   CE,           // clock enable, freezes state when low
    input  wire                   PSEL,         // apb select
    input  wire                   PENABLE,      // apb access phase
    input  wire                   PWRITE,       // apb direction
    input  wire [11:0]            PADDR,        // apb byte address
    input  wire [31:0]            PWDATA,       // apb write data
    output reg  [31:0]            PRDATA,       // apb read data
    output wire                   PREADY,       // apb ready
    output wire                   PSLVERR,      // apb error on unmapped address
    input  wire [`VC_NUM_IRQ-1:0] IRQ_SET,      // peripheral request pulses
    input  wire                   OSC_FAIL,     // oscillator failure event
    input  wire                   ADDR_ERR,     // address error event
    input  wire                   ECC_DED,      // ecc double-bit error event
    input  wire                   SW_TRAP,      // software trap request
    input  wire                   STACK_ERR,    // stack error event
    input  wire [5:0]             MATH_EVENT,   // ova, ovb, cata, catb, shift, div0
    input  wire                   NVM_ADDR_ERR, // nvm address error event
    input  wire                   DMA_ADDR_ERR, // dma address error event
    input  wire                   LOOP_OVF,     // loop stack overflow event
    output reg                    VEC_VALID,    // a vector is presented
    output reg  [7:0]             VEC_NUMBER,   // vector number
    output reg  [23:0]            VEC_ADDR,     // table entry address
    output reg  [3:0]             VEC_LEVEL,    // priority, traps 9..15, users 1..7
    output reg                    FETCH_START,  // one pulse after reset release
    output reg  [23:0]            FETCH_ADDR    // first fetch address
);
    genvar g;

    // true when addr falls in a block of words starting at base
    function hit;
        input [11:0] addr;
        input [11:0] base;
        input [6:0]  words;
        begin
            hit = (addr >= base) && ({1'b0, addr} < {1'b0, base} + {4'h0, words, 2'b00}) && (addr[1:0] == 2'b00);
        end
    endfunction

    reg  [15:0] trap_control_first;   // osc/addr/stack/math flags, math types and enables
    reg  [15:0] trap_control_second;  // alternate table and software trap enables
    reg  [15:0] trap_control_third;   // soft trap flags
    reg  [15:0] trap_control_fourth;  // hard trap flags
    reg  [12:0] boot_segment_limit;   // boot segment size in pages
    reg         in_reset_last;        // reset seen on the previous edge

    wire [16*`VC_FLAG_WORDS-1:0] request_flag_reg;      // flag bits, all words
    wire [16*`VC_FLAG_WORDS-1:0] request_enable_reg;    // enable bits, all words
    wire [16*`VC_PRIO_WORDS-1:0] request_priority_reg;  // priority words as read
    wire [3*`VC_NUM_IRQ-1:0]     prio_flat;             // packed 3-bit levels

    // apb decode
    wire       access    = PSEL & PENABLE & CE;
    wire       wr_en     = access & PWRITE;
    wire       flag_hit  = hit(PADDR, `VC_OFS_FLAG_BASE, `VC_FLAG_WORDS);
    wire       en_hit    = hit(PADDR, `VC_OFS_EN_BASE, `VC_FLAG_WORDS);
    wire       prio_hit  = hit(PADDR, `VC_OFS_PRIO_BASE, `VC_PRIO_WORDS);
    wire       t1_hit    = hit(PADDR, `VC_OFS_TRAP1, 7'd1);
    wire       t2_hit    = hit(PADDR, `VC_OFS_TRAP2, 7'd1);
    wire       t3_hit    = hit(PADDR, `VC_OFS_TRAP3, 7'd1);
    wire       t4_hit    = hit(PADDR, `VC_OFS_TRAP4, 7'd1);
    wire       bs_hit    = hit(PADDR, `VC_OFS_BOOT_LIM, 7'd1);
    wire       mapped    = flag_hit | en_hit | prio_hit | t1_hit | t2_hit | t3_hit | t4_hit | bs_hit;
    wire [5:0] word_idx  = PADDR[7:2];  // word within a block

    assign PREADY  = CE;                          // zero wait states unless frozen
    assign PSLVERR = PSEL & PENABLE & ~mapped;    // unmapped access is an error

    // per-source flag and enable bits; only implemented sources hold state
    generate
        for (g = 0; g < 16*`VC_FLAG_WORDS; g = g + 1) begin : src_bits
            if (g < `VC_NUM_IRQ) begin : impl
                reg flag;  // pending flag
                reg en;    // enable
                always @(posedge CLK) begin
                    if (RESET) begin
                        flag <= 1'b0;
                        en   <= 1'b0;
                    end else if (CE) begin
                        // a new request wins over a software clear
                        flag <= ((wr_en && flag_hit && word_idx[3:0] == g/16) ? PWDATA[g%16] : flag)
                                | IRQ_SET[g];
                        if (wr_en && en_hit && word_idx[3:0] == g/16) begin
                            en <= PWDATA[g%16];
                        end
                    end
                end
                assign request_flag_reg[g]   = flag;
                assign request_enable_reg[g] = en;
            end else begin : unimpl
                assign request_flag_reg[g]   = 1'b0;  // reads as zero
                assign request_enable_reg[g] = 1'b0;
            end
        end
    endgenerate

    // 3-bit priority fields, four to a word at bits 2:0, 6:4, 10:8, 14:12
    generate
        for (g = 0; g < 4*`VC_PRIO_WORDS; g = g + 1) begin : prio_fields
            if (g < `VC_NUM_IRQ) begin : impl
                reg [2:0] lvl;  // user priority of source g
                always @(posedge CLK) begin
                    if (RESET) begin
                        lvl <= 3'h0;
                    end else if (CE && wr_en && prio_hit && word_idx == g/4) begin
                        lvl <= PWDATA[4*(g%4) +: 3];
                    end
                end
                assign prio_flat[3*g +: 3]              = lvl;
                assign request_priority_reg[4*g +: 4]   = {1'b0, lvl};
            end else begin : unimpl
                assign request_priority_reg[4*g +: 4]   = 4'h0;
            end
        end
    endgenerate

    // math errors: overflow A and B have their own enables, the other four share one
    wire [5:0]  math_hit   = MATH_EVENT & {trap_control_first[`VC_T1_OVA_EN], trap_control_first[`VC_T1_OVB_EN],
                                           {4{trap_control_first[`VC_T1_CAT_EN]}}};
    // type bits raised this cycle, plus the shared flag when any is raised
    wire [15:0] math_set   = ({15'h0, math_hit[5]} << `VC_T1_OVA_TYPE) | ({15'h0, math_hit[4]} << `VC_T1_OVB_TYPE)
                           | ({15'h0, math_hit[3]} << `VC_T1_CATA_TYPE) | ({15'h0, math_hit[2]} << `VC_T1_CATB_TYPE)
                           | ({15'h0, math_hit[1]} << `VC_T1_SHIFT_TYPE) | ({15'h0, math_hit[0]} << `VC_T1_DIV0_TYPE)
                           | ({15'h0, |math_hit} << `VC_T1_MATH_FLAG);

    // trap control registers; hardware events win over a software write
    always @(posedge CLK) begin
        if (RESET) begin
            trap_control_first  <= `VC_RST_WORD;
            trap_control_second <= `VC_RST_WORD;
            trap_control_third  <= `VC_RST_WORD;
            trap_control_fourth <= `VC_RST_WORD;
            boot_segment_limit  <= `VC_RST_BOOT_LIM;
        end else if (CE) begin
            trap_control_first  <= ((wr_en && t1_hit) ? PWDATA[15:0] : trap_control_first) | math_set;
            trap_control_third  <= (wr_en && t3_hit) ? PWDATA[15:0] : trap_control_third;
            trap_control_fourth <= (wr_en && t4_hit) ? PWDATA[15:0] : trap_control_fourth;
            if (wr_en && t2_hit) begin
                trap_control_second <= PWDATA[15:0];
            end
            if (wr_en && bs_hit) begin
                boot_segment_limit <= PWDATA[12:0];
            end
            // non-maskable traps set their flags unconditionally
            if (OSC_FAIL) begin
                trap_control_first[`VC_T1_OSC_FLAG] <= 1'b1;
            end
            if (ADDR_ERR) begin
                trap_control_first[`VC_T1_ADDR_FLAG] <= 1'b1;
            end
            if (STACK_ERR) begin
                trap_control_first[`VC_T1_STACK_FLAG] <= 1'b1;
            end
            // soft trap causes each own a flag
            if (NVM_ADDR_ERR) begin
                trap_control_third[`VC_T3_NVM_FLAG] <= 1'b1;
            end
            if (DMA_ADDR_ERR) begin
                trap_control_third[`VC_T3_DMA_FLAG] <= 1'b1;
            end
            if (LOOP_OVF) begin
                trap_control_third[`VC_T3_LOOP_FLAG] <= 1'b1;
            end
            // hard trap causes
            if (ECC_DED) begin
                trap_control_fourth[`VC_T4_ECC_FLAG] <= 1'b1;
            end
            if (SW_TRAP && trap_control_second[`VC_T2_SWTRAP_EN]) begin
                trap_control_fourth[`VC_T4_SWTRAP_FLAG] <= 1'b1;
            end
        end
    end

    // peripheral arbitration
    wire       irq_found;   // an enabled request with nonzero level pends
    wire [7:0] irq_winner;  // its request number
    wire [2:0] irq_level;   // its level

    request_arbiter arbiter (
        .pending (request_flag_reg[`VC_NUM_IRQ-1:0] & request_enable_reg[`VC_NUM_IRQ-1:0]),
        .levels  (prio_flat),
        .found   (irq_found),
        .winner  (irq_winner),
        .level   (irq_level)
    );

    // trap pending terms
    wire osc_pend   = trap_control_first[`VC_T1_OSC_FLAG];
    wire addr_pend  = trap_control_first[`VC_T1_ADDR_FLAG];
    wire hard_pend  = trap_control_fourth[`VC_T4_ECC_FLAG] | trap_control_fourth[`VC_T4_SWTRAP_FLAG];
    wire stack_pend = trap_control_first[`VC_T1_STACK_FLAG];
    wire math_pend  = trap_control_first[`VC_T1_MATH_FLAG];
    wire soft_pend  = trap_control_third[`VC_T3_NVM_FLAG] | trap_control_third[`VC_T3_DMA_FLAG]
                      | trap_control_third[`VC_T3_LOOP_FLAG];

    // table base: zero, or the last boot segment page when the alternate table is on
    wire [23:0] limit_less_one = {11'h000, boot_segment_limit - 13'h0001};
    wire [23:0] table_base     = trap_control_second[`VC_T2_ALT_EN] ?
                                 (limit_less_one * `VC_ALT_PAGE_SIZE) : 24'h000000;

    reg         next_valid;   // vector to present
    reg  [7:0]  next_number;  // its vector number
    reg  [3:0]  next_level;   // its priority
    reg  [23:0] next_offset;  // its offset in the table

    // select the winner: fixed trap order first, then the peripheral winner
    always @* begin
        next_valid  = 1'b1;
        next_number = 8'h00;
        next_level  = 4'h0;
        if (osc_pend) begin
            next_number = `VC_VEC_OSC_FAIL;
            next_level  = `VC_PRI_OSC_FAIL;
        end else if (addr_pend) begin
            next_number = `VC_VEC_ADDR_ERR;
            next_level  = `VC_PRI_ADDR_ERR;
        end else if (hard_pend) begin
            next_number = `VC_VEC_HARD;
            next_level  = `VC_PRI_HARD;
        end else if (stack_pend) begin
            next_number = `VC_VEC_STACK;
            next_level  = `VC_PRI_STACK;
        end else if (math_pend) begin
            next_number = `VC_VEC_MATH;
            next_level  = `VC_PRI_MATH;
        end else if (soft_pend) begin
            next_number = `VC_VEC_SOFT;
            next_level  = `VC_PRI_SOFT;
        end else if (irq_found) begin
            // traps always beat user levels, which top out at 7
            next_number = irq_winner + `VC_IRQ_TO_VECTOR;
            next_level  = {1'b0, irq_level};
        end else begin
            next_valid  = 1'b0;
        end
        // entry offset: two words per slot above the trap base
        if (next_number >= `VC_IRQ_TO_VECTOR) begin
            next_offset = `VC_FIRST_IRQ_ADDR + {15'h0000, next_number - `VC_IRQ_TO_VECTOR, 1'b0};
        end else begin
            next_offset = `VC_TRAP_BASE_ADDR + {15'h0000, next_number, 1'b0};
        end
    end

    // registered vector outputs; nothing is presented in or for reset
    always @(posedge CLK) begin
        if (RESET) begin
            VEC_VALID  <= 1'b0;
            VEC_NUMBER <= 8'h00;
            VEC_ADDR   <= 24'h000000;
            VEC_LEVEL  <= 4'h0;
        end else if (CE) begin
            VEC_VALID  <= next_valid;
            VEC_NUMBER <= next_number;
            VEC_ADDR   <= table_base + next_offset;
            VEC_LEVEL  <= next_level;
        end
    end

    // start of execution after reset: a direct fetch from zero, no lookup
    always @(posedge CLK) begin
        if (RESET) begin
            in_reset_last <= 1'b1;
            FETCH_START   <= 1'b0;
            FETCH_ADDR    <= `VC_RESET_FETCH_ADDR;
        end else if (CE) begin
            in_reset_last <= 1'b0;
            FETCH_START   <= in_reset_last;
        end
    end

    // read data latched in the setup phase
    always @(posedge CLK) begin
        if (RESET) begin
            PRDATA <= 32'h00000000;
        end else if (CE && PSEL && !PENABLE && !PWRITE) begin
            if (t1_hit) begin
                PRDATA <= {16'h0000, trap_control_first};
            end else if (t2_hit) begin
                PRDATA <= {16'h0000, trap_control_second};
            end else if (t3_hit) begin
                PRDATA <= {16'h0000, trap_control_third};
            end else if (t4_hit) begin
                PRDATA <= {16'h0000, trap_control_fourth};
            end else if (bs_hit) begin
                PRDATA <= {19'h00000, boot_segment_limit};
            end else if (flag_hit) begin
                PRDATA <= {16'h0000, request_flag_reg[16*word_idx[3:0] +: 16]};
            end else if (en_hit) begin
                PRDATA <= {16'h0000, request_enable_reg[16*word_idx[3:0] +: 16]};
            end else if (prio_hit) begin
                PRDATA <= {16'h0000, request_priority_reg[16*word_idx +: 16]};
            end else begin
                PRDATA <= 32'h00000000;  // unmapped reads as zero
            end
        end
    end
endmodule
`default_nettype wire

// ==== inc/vector_ctrl_consts.vh ====
// constants for the trap and interrupt vectoring block
`ifndef VECTOR_CTRL_CONSTS_VH
`define VECTOR_CTRL_CONSTS_VH

// start point after reset and table geometry
`define VC_RESET_FETCH_ADDR  24'h000000
`define VC_FIRST_IRQ_ADDR    24'h000014
`define VC_TRAP_BASE_ADDR    24'h000004
`define VC_ALT_PAGE_SIZE     24'h000800
`define VC_IRQ_TO_VECTOR     8'h08
`define VC_NUM_IRQ           246
`define VC_FLAG_WORDS        7'h10
`define VC_PRIO_WORDS        7'h40

// trap vector numbers (address = trap base + 2 * number)
`define VC_VEC_OSC_FAIL      8'h00
`define VC_VEC_ADDR_ERR      8'h01
`define VC_VEC_HARD          8'h02
`define VC_VEC_STACK         8'h03
`define VC_VEC_MATH          8'h04
`define VC_VEC_SOFT          8'h06

// fixed trap priorities
`define VC_PRI_OSC_FAIL      4'hF
`define VC_PRI_ADDR_ERR      4'hE
`define VC_PRI_HARD          4'hD
`define VC_PRI_STACK         4'hC
`define VC_PRI_MATH          4'hB
`define VC_PRI_SOFT          4'h9

// trap_control_first bit positions
`define VC_T1_OSC_FLAG       1
`define VC_T1_STACK_FLAG     2
`define VC_T1_ADDR_FLAG      3
`define VC_T1_MATH_FLAG      4
`define VC_T1_DIV0_TYPE      6
`define VC_T1_SHIFT_TYPE     7
`define VC_T1_CAT_EN         8
`define VC_T1_OVB_EN         9
`define VC_T1_OVA_EN         10
`define VC_T1_CATB_TYPE      11
`define VC_T1_CATA_TYPE      12
`define VC_T1_OVB_TYPE       13
`define VC_T1_OVA_TYPE       14
// trap_control_second bit positions
`define VC_T2_ALT_EN         8
`define VC_T2_SWTRAP_EN      13
// trap_control_third bit positions
`define VC_T3_LOOP_FLAG      4
`define VC_T3_DMA_FLAG       5
`define VC_T3_NVM_FLAG       8
// trap_control_fourth bit positions
`define VC_T4_SWTRAP_FLAG    0
`define VC_T4_ECC_FLAG       1

// register byte offsets
`define VC_OFS_TRAP1         12'h000
`define VC_OFS_TRAP2         12'h004
`define VC_OFS_TRAP3         12'h008
`define VC_OFS_TRAP4         12'h00C
`define VC_OFS_BOOT_LIM      12'h010
`define VC_OFS_FLAG_BASE     12'h100
`define VC_OFS_EN_BASE       12'h200
`define VC_OFS_PRIO_BASE     12'h300

// reset values
`define VC_RST_WORD          16'h0000
`define VC_RST_BOOT_LIM      13'h0000

`endif

// ==== testbench/core_model.sv ====
// processor core model that takes presented vectors
`timescale 1ns/1ps
`default_nettype none
module core_model (
    input wire logic        CLK, RESET, VEC_VALID, // clock, reset, vector present
    input wire logic [7:0]  VEC_NUMBER,            // vector number
    input wire logic [23:0] VEC_ADDR,              // entry address
    input wire logic [3:0]  VEC_LEVEL,             // priority
    output logic            took,                  // a new vector was taken
    output logic [35:0]     taken                  // number, address, level taken
);
    logic [7:0]  seen;           // last number seen
    logic        was;            // vector present last cycle
    logic [23:0] handler [256];  // firmware table, unused slots reset the part
    initial for (int i = 0; i < 256; i++) handler[i] = 24'h000200;
    // take a vector when one appears or a different one replaces it
    always @(posedge CLK) begin
        took <= !RESET && VEC_VALID && (!was || VEC_NUMBER != seen);
        taken <= {VEC_NUMBER, VEC_ADDR, VEC_LEVEL};
        was <= VEC_VALID && !RESET;
        seen <= VEC_NUMBER;
    end
endmodule
`default_nettype wire

// ==== testbench/test_trap_and_interrupt_vectoring.sv ====
// self-checking bench for the vectoring block
`timescale 1ns/1ps
`default_nettype none
`include "vector_ctrl_consts.vh"
module test_trap_and_interrupt_vectoring;
    logic clk = 0, reset = 1, ce = 1, psel = 0, penable = 0, pwrite = 0, swt = 0, took, vv, fs, pready, err, perr;
    logic [6:0]  ev = 0;                  // osc, addr, ecc, stack, nvm, dma, loop events
    logic [5:0]  math = 0;                // math error events
    logic [11:0] paddr = 0;               // apb address
    logic [31:0] pwdata = 0, prdata, rd, seed = 32'h2e01;
    logic [`VC_NUM_IRQ-1:0] irq = 0, bit0 = 1;
    logic [7:0]  vn, tn [7] = '{0, 1, 2, 3, 6, 6, 6};
    logic [3:0]  vl, tl [7] = '{15, 14, 13, 12, 9, 9, 9};
    logic [23:0] va, fa;
    logic [35:0] taken, notes [$];        // expected {number, address, level}
    int miscompares = 0, comparisons = 0, cycles = 0, lim, reqs [6] = '{2, 48, 81, 116, 120, 245}, mb [6] = '{6, 7, 11, 12, 13, 14};
    trap_and_interrupt_vectoring uut (.CLK(clk), .RESET(reset), .CE(ce), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(perr),
        .IRQ_SET(irq), .OSC_FAIL(ev[0]), .ADDR_ERR(ev[1]), .ECC_DED(ev[2]), .SW_TRAP(swt), .STACK_ERR(ev[3]),
        .MATH_EVENT(math), .NVM_ADDR_ERR(ev[4]), .DMA_ADDR_ERR(ev[5]), .LOOP_OVF(ev[6]), .VEC_VALID(vv),
        .VEC_NUMBER(vn), .VEC_ADDR(va), .VEC_LEVEL(vl), .FETCH_START(fs), .FETCH_ADDR(fa));
    core_model core (.CLK(clk), .RESET(reset), .VEC_VALID(vv), .VEC_NUMBER(vn), .VEC_ADDR(va),
        .VEC_LEVEL(vl), .took(took), .taken(taken));
    initial forever #5 clk = ~clk;
    function logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    task chk(input logic ok, input string m);
        comparisons++;
        if (!ok) begin
            miscompares++;
            $display("FAIL %0t %s", $time, m);
        end
    endtask
    // one apb transfer, held until pready is seen high
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = perr;
        psel <= 0;
        penable <= 0;
    endtask
    task note(input logic [7:0] n, input logic [23:0] a, input logic [3:0] l);
        notes.push_back({n, a, l});
    endtask
    // one-cycle event pulses
    task fire(input logic [`VC_NUM_IRQ-1:0] m, input logic [6:0] e, input logic [5:0] x, input logic s);
        @(posedge clk);
        irq <= m;
        ev <= e;
        math <= x;
        swt <= s;
        @(posedge clk);
        irq <= 0;
        ev <= 0;
        math <= 0;
        swt <= 0;
    endtask
    // wait for the noted vectors, then check presence
    task settle(input logic want);
        int n;
        n = 0;
        while (notes.size() != 0 && n++ < 40) @(posedge clk);
        repeat (3) @(posedge clk);
        chk(notes.size() == 0 && vv === want, "vector state");
    endtask
    task clr;
        apb(1, 12'h000, 0);
        apb(1, 12'h008, 0);
        apb(1, 12'h00C, 0);
        apb(1, 12'h100, 0);
    endtask
    // one peripheral request: enable, priority, raise, clear
    task req_check(input int r, input logic [23:0] base);
        seed = xs(seed);
        apb(1, 12'(12'h200 + 4 * (r / 16)), 32'(1 << (r % 16)));
        apb(1, 12'(12'h300 + 4 * (r / 4)), 32'((1 + seed % 7) << (4 * (r % 4))));
        note(8'(r + 8), base + 24'(24'h14 + 2 * r), 4'(1 + seed % 7));
        fire(bit0 << r, 0, 0, 0);
        settle(1);
        apb(1, 12'(12'h100 + 4 * (r / 16)), 0);
        settle(0);
    endtask
    // compare each vector the core takes with the oldest note
    always @(negedge clk) if (took === 1'b1) begin
        chk(notes.size() != 0 && taken === notes[0], "vector mismatch");
        if (notes.size() != 0) void'(notes.pop_front());
    end
    initial begin
        repeat (20) @(posedge clk);
        reset <= 0;
        @(posedge clk);
        @(negedge clk);
        chk(fs === 1'b1 && fa === 24'h000000 && vv === 1'b0, "fetch start");
        for (int a = 0; a <= 16; a += 4) begin
            apb(0, 12'(a), 0);
            chk(rd === 32'h00000000, "reset value");
        end
        apb(0, 12'h0FC, 32'h0000FFFF);
        chk(rd === 32'h00000000 && err === 1'b1, "unmapped");
        foreach (reqs[k]) req_check(reqs[k], 24'h000000);
        seed = xs(seed);
        lim = 2 + seed % 16;
        apb(1, 12'h010, 32'(lim));
        apb(1, 12'h004, 32'h00000100);
        req_check(2, 24'((lim - 1) * 24'h800));
        apb(1, 12'h004, 0);
        apb(1, 12'h200, 32'h00000050);
        for (int t = 0; t < 2; t++) begin
            apb(1, 12'h304, t ? 32'h00000503 : 32'h00000303);
            note(t ? 14 : 12, t ? 24'h20 : 24'h1C, t ? 5 : 3);
            fire(bit0 << 4 | bit0 << 6, 0, 0, 0);
            settle(1);
            note(t ? 12 : 14, t ? 24'h1C : 24'h20, 3);
            apb(1, 12'h100, t ? 32'h00000010 : 32'h00000040);
            settle(1);
            apb(1, 12'h100, 0);
            settle(0);
        end
        apb(1, 12'h200, 32'h00000004);
        apb(1, 12'h300, 32'h00000700);
        for (int k = 0; k < 7; k++) begin
            note(tn[k], 24'(24'h4 + 2 * tn[k]), tl[k]);
            fire(bit0 << 2, 7'(1 << k), 0, 0);
            settle(1);
            note(10, 24'h18, 7);
            clr;
            settle(0);
        end
        fire(bit0 << 4, 0, 6'h3F, 1);
        settle(0);
        apb(1, 12'h004, 32'h00002000);
        note(2, 24'h8, 13);
        fire(0, 0, 0, 1);
        settle(1);
        clr;
        for (int j = 0; j < 6; j++) begin
            apb(1, 12'h000, 32'h00000700);
            note(4, 24'hC, 11);
            fire(0, 0, 6'(1 << j), 0);
            settle(1);
            apb(0, 12'h000, 0);
            chk(rd[4] === 1'b1 && rd[mb[j]] === 1'b1, "math type");
            clr;
            settle(0);
        end
        print_verdict();
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            print_verdict();
        end
    end
    task print_verdict;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
endmodule
`default_nettype wire

// ==== testbench/vectoring_sva.sv ====
// assertion checker for the vectoring block
`timescale 1ns/1ps
`default_nettype none
module vectoring_sva (
    input wire logic        CLK, RESET, CE, PSEL, VEC_VALID, FETCH_START, OSC_FAIL, // watched ports
    input wire logic [7:0]  VEC_NUMBER,                                             // vector number
    input wire logic [23:0] VEC_ADDR, FETCH_ADDR,                                   // addresses
    input wire logic [3:0]  VEC_LEVEL                                               // presented priority
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RESET);
    property p_start; $past(RESET) && !RESET && CE |=> FETCH_START; endproperty
    a_start: assert property (p_start) else $error("no fetch start after reset");
    property p_once; FETCH_START |-> FETCH_ADDR == 24'h000000 ##1 !FETCH_START; endproperty
    a_once: assert property (p_once) else $error("bad fetch start pulse");
    property p_novec; $past(RESET) && !RESET |-> !VEC_VALID; endproperty
    a_novec: assert property (p_novec) else $error("vector out of reset");
    property p_addr; VEC_VALID |-> VEC_ADDR[10:0] == {2'b00, VEC_NUMBER, 1'b0} + 11'h004; endproperty
    a_addr: assert property (p_addr) else $error("vector address wrong");
    property p_tlvl; VEC_VALID && VEC_NUMBER < 8'h08 |-> VEC_LEVEL == (VEC_NUMBER == 8'h00 ? 4'hF :
        VEC_NUMBER == 8'h01 ? 4'hE : VEC_NUMBER == 8'h02 ? 4'hD : VEC_NUMBER == 8'h03 ? 4'hC :
        VEC_NUMBER == 8'h04 ? 4'hB : VEC_NUMBER == 8'h06 ? 4'h9 : 4'h0); endproperty
    a_tlvl: assert property (p_tlvl) else $error("trap priority wrong");
    property p_ulvl; VEC_VALID && VEC_NUMBER > 8'h07 |-> VEC_LEVEL != 4'h0 && VEC_LEVEL < 4'h8; endproperty
    a_ulvl: assert property (p_ulvl) else $error("user priority out of range");
    property p_osc; OSC_FAIL && CE ##1 CE |=> VEC_VALID && VEC_NUMBER == 8'h00; endproperty
    a_osc: assert property (p_osc) else $error("oscillator trap not presented");
    property p_stand; VEC_VALID && !PSEL && !$past(PSEL) |=> VEC_VALID; endproperty
    a_stand: assert property (p_stand) else $error("vector dropped without write");
endmodule
bind trap_and_interrupt_vectoring vectoring_sva chk (.CLK(CLK), .RESET(RESET), .CE(CE), .PSEL(PSEL),
    .VEC_VALID(VEC_VALID), .FETCH_START(FETCH_START), .OSC_FAIL(OSC_FAIL), .VEC_NUMBER(VEC_NUMBER),
    .VEC_ADDR(VEC_ADDR), .FETCH_ADDR(FETCH_ADDR), .VEC_LEVEL(VEC_LEVEL));
`default_nettype wire
